// ===== rtl/bcs_pkg.sv
// Package: constants for the board control and status register set
package bcs_pkg;
   // Bus identity and command codes
   localparam logic [6:0] SLV_ADDR = 7'h5c;
   localparam logic [7:0] CMD_CTRL_WR = 8'ha0;
   localparam logic [7:0] CMD_CTRL_RD = 8'ha1;
   localparam logic [7:0] POWER_FAIL_STATUS_REG_CLR = 8'hb0;
   localparam logic [7:0] POWER_STATUS_READ = 8'hb1;
   localparam logic [7:0] WDOG_AND_POWER_STATUS_REG_CLR = 8'hb2;
   localparam logic [7:0] WDOG_POWER_STATUS_READ = 8'hb3;
   localparam logic [7:0] CMD_REV_RD = 8'hc1;

   // Control register fields
   localparam int CTL_GREEN = 7;
   localparam int CTL_SW_DIS = 6;
   localparam int CTL_SW_ACT = 5;
   localparam int CTL_SEL_HI = 4;
   localparam int CTL_SEL_LO = 3;
   localparam int CTL_KICK = 2;
   localparam int CTL_RED = 1;
   localparam int CTL_FULL_RST = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // Status fields; reserved bits of status 0 read as zero
   localparam logic [7:0] STAT0_MASK = 8'hed;
   localparam int ST1_ARMED = 7;
   localparam int ST1_TIMEOUT = 6;
   localparam int ST1_HALF = 5;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
   localparam int RST_PULSE_NS = 1000;
   localparam logic [7:0] RST_PULSE_CYC =
      8'((RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int WD_MS_W = 18;
   localparam logic [WD_MS_W-1:0] WD_MS_00 = 18'd2000;
   localparam logic [WD_MS_W-1:0] WD_MS_10 = 18'd10000;
   localparam logic [WD_MS_W-1:0] WD_MS_01 = 18'd50000;
   localparam logic [WD_MS_W-1:0] WD_MS_11 = 18'd250000;
   localparam logic [9:0] BLINK_HALF_MS = 10'd500;

   // Revision byte, value arbitrary
   localparam logic [7:0] LOGIC_REV_DEF = 8'h01;

   // Bus slave states, Gray coded along the usual path
   typedef enum logic [3:0] {
      SB_IDLE = 4'h0,
      SB_ADDR = 4'h1,
      SB_ADDR_ACK = 4'h3,
      SB_CMD = 4'h2,
      SB_CMD_ACK = 4'h6,
      SB_WDATA = 4'h7,
      SB_WDATA_ACK = 4'h5,
      SB_TX = 4'h4,
      SB_IGNORE = 4'hc
   } bcs_sb_st_t;
endpackage : bcs_pkg

// ===== rtl/bcs_wd_if.sv
// Interface: links the register set to its watchdog timer
`timescale 1ns/1ps
`default_nettype none
interface bcs_wd_if;
   logic kick;
   logic [1:0] sel;
   logic sys_rst;
   logic armed;
   logic half;
   logic expire;
   logic tick;
   modport ctl (output kick, sel, sys_rst, input armed, half, expire, tick);
   modport wd (input kick, sel, sys_rst, output armed, half, expire, tick);
endinterface : bcs_wd_if
`default_nettype wire

// ===== rtl/bcs_wdog.sv
// Watchdog timer with millisecond prescaler
`timescale 1ns/1ps
`default_nettype none
module bcs_wdog
   import bcs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link to the register set
   bcs_wd_if.wd wi
);
   localparam int PW = $clog2(TICK_CYC + 1);

   if (TICK_CYC < 2) begin : g_bad_tick
      $error("bcs_wdog: TICK_CYC must be at least 2");
   end

   typedef struct packed {
      logic [PW-1:0] pre;
      logic tick;
      logic kick_q;
      logic armed;
      logic [WD_MS_W-1:0] cnt;
      logic half;
      logic expire;
   } bcs_wd_t;

   bcs_wd_t r, n;

   // Bit 4 selects the first printed digit, bit 3 the second
   function automatic logic [WD_MS_W-1:0] period_ms(input logic [1:0] sel);
      case (sel)
         2'b00: period_ms = WD_MS_00;
         2'b10: period_ms = WD_MS_10;
         2'b01: period_ms = WD_MS_01;
         default: period_ms = WD_MS_11;
      endcase
   endfunction : period_ms

   always_comb begin
      logic [WD_MS_W-1:0] lim;
      logic kick_edge;
      lim = period_ms(wi.sel);
      kick_edge = wi.kick ^ r.kick_q;
      n = r;
      n.tick = 1'b0;
      n.expire = 1'b0;
      n.kick_q = wi.kick;
      if (r.pre == PW'(TICK_CYC - 1)) begin
         n.pre = '0;
         n.tick = 1'b1;
      end else begin
         n.pre = r.pre + PW'(1);
      end
      if (wi.sys_rst) begin
         // Inactive after any system reset
         n.armed = 1'b0;
         n.cnt = '0;
         n.kick_q = 1'b0;
      end else if (kick_edge) begin
         // Either edge restarts; the first one arms
         n.armed = 1'b1;
         n.cnt = '0;
      end else if (r.armed && r.tick) begin
         if (r.cnt == lim - WD_MS_W'(1)) begin
            n.expire = 1'b1;
            n.armed = 1'b0;
            n.cnt = '0;
         end else begin
            n.cnt = r.cnt + WD_MS_W'(1);
         end
      end
      n.half = n.armed && (n.cnt >= (lim >> 1));
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign wi.armed = r.armed;
   assign wi.half = r.half;
   assign wi.expire = r.expire;
   assign wi.tick = r.tick;
endmodule : bcs_wdog
`default_nettype wire

// ===== rtl/bcs_regs.sv
// Board control and status registers behind a byte-data bus slave
`timescale 1ns/1ps
`default_nettype none
module bcs_regs
   import bcs_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYC_DEF,
   parameter logic [7:0] LOGIC_REV = LOGIC_REV_DEF
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Bus pins; data line is open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Board events
   input wire logic sys_rst_in,
   input wire logic handle_sw_i,
   input wire logic [7:0] pf0_evt_i,
   input wire logic [4:0] pf1_evt_i,
   // Board outputs
   output logic green_indicator_on,
   output logic red_indicator_out,
   output logic full_reset_out,
   output logic power_event_out
);
   typedef struct packed {
      bcs_sb_st_t st;
      logic scl_q;
      logic sda_q;
      logic [2:0] cnt;
      logic full;
      logic rd;
      logic [7:0] sh;
      logic [7:0] cmd;
      logic sda_oe;
      logic sda_o;
      logic [7:0] ctrl;
      logic [7:0] stat0;
      logic wdto;
      logic [4:0] pf1;
      logic [7:0] rst_cnt;
      logic full_rst;
      logic sw_q;
      logic pwr_evt;
      logic [9:0] blink_cnt;
      logic blink_ph;
      logic green;
      logic red;
   } bcs_regs_t;

   bcs_regs_t r, n;
   bcs_wd_if wdl ();

   // The blink counter shares the watchdog prescaler; the reset pulse counts clock cycles
   if (TICK_CYC < 2) begin : g_bad_tick
      $error("bcs_regs: TICK_CYC must be at least 2");
   end

   // Reset pulse must last at least 2 cycles of its 8-bit down counter
   if (RST_PULSE_CYC < 8'd2) begin : g_bad_pulse
      $error("bcs_regs: reset pulse must last at least 2 cycles");
   end

   logic start_c;
   logic stop_c;
   logic rise_c;
   logic fall_c;
   logic sysrst_c;

   assign start_c = r.scl_q & scl_i & r.sda_q & ~sda_i;
   assign stop_c = r.scl_q & scl_i & ~r.sda_q & sda_i;
   assign rise_c = ~r.scl_q & scl_i;
   assign fall_c = r.scl_q & ~scl_i;
   // Own reset pulse ending, or a reset from elsewhere on the board
   assign sysrst_c = (r.rst_cnt == 8'h01) | sys_rst_in;

   assign wdl.kick = r.ctrl[CTL_KICK];
   assign wdl.sel = {r.ctrl[CTL_SEL_HI], r.ctrl[CTL_SEL_LO]};
   assign wdl.sys_rst = sysrst_c;

   bcs_wdog #(
      .TICK_CYC(TICK_CYC)
   ) u_wdog (
      .mclk(mclk),
      .rst(rst),
      .wi(wdl)
   );

   // Sticky capture; an event in the clearing cycle is kept
   function automatic logic [7:0] sticky(input logic [7:0] held, input logic [7:0] evt);
      sticky = held | evt;
   endfunction : sticky

   function automatic logic [7:0] read_mux(input logic [7:0] cmd, input bcs_regs_t s,
                                           input logic armed, input logic half);
      case (cmd)
         CMD_CTRL_RD: read_mux = s.ctrl;
         POWER_STATUS_READ: read_mux = s.stat0 & STAT0_MASK;
         WDOG_POWER_STATUS_READ: read_mux = {armed, s.wdto, half, s.pf1};
         CMD_REV_RD: read_mux = LOGIC_REV;
         // Write-only and unknown codes read as zero
         default: read_mux = RD_UNMAPPED;
      endcase
   endfunction : read_mux

   always_comb begin
      logic [7:0] tx;
      logic rst_req;
      tx = read_mux(r.cmd, r, wdl.armed, wdl.half);
      rst_req = 1'b0;
      n = r;
      n.scl_q = scl_i;
      n.sda_q = sda_i;
      n.sda_o = 1'b0;
      n.pwr_evt = 1'b0;

      // Byte-data slave; start and stop take priority over bit timing
      if (stop_c) begin
         n.st = SB_IDLE;
         n.sda_oe = 1'b0;
      end else if (start_c) begin
         n.st = SB_ADDR;
         n.cnt = '0;
         n.full = 1'b0;
         n.sda_oe = 1'b0;
      end else if (rise_c && (r.st == SB_ADDR || r.st == SB_CMD || r.st == SB_WDATA)) begin
         n.sh = {r.sh[6:0], sda_i};
         n.cnt = r.cnt + 3'd1;
         n.full = (r.cnt == 3'd7);
      end else if (fall_c) begin
         case (r.st)
            SB_ADDR: begin
               if (r.full) begin
                  n.full = 1'b0;
                  if (r.sh[7:1] == SLV_ADDR) begin
                     n.sda_oe = 1'b1;
                     n.rd = r.sh[0];
                     n.st = SB_ADDR_ACK;
                  end else begin
                     n.st = SB_IGNORE;
                  end
               end
            end
            SB_ADDR_ACK: begin
               if (r.rd) begin
                  n.sh = tx;
                  n.sda_oe = ~tx[7];
                  n.cnt = '0;
                  n.st = SB_TX;
               end else begin
                  n.sda_oe = 1'b0;
                  n.st = SB_CMD;
               end
            end
            SB_CMD: begin
               if (r.full) begin
                  n.full = 1'b0;
                  n.cmd = r.sh;
                  n.sda_oe = 1'b1;
                  n.st = SB_CMD_ACK;
               end
            end
            SB_CMD_ACK: begin
               n.sda_oe = 1'b0;
               n.st = SB_WDATA;
            end
            SB_WDATA: begin
               if (r.full) begin
                  n.full = 1'b0;
                  n.sda_oe = 1'b1;
                  n.st = SB_WDATA_ACK;
                  case (r.cmd)
                     CMD_CTRL_WR: n.ctrl = r.sh;
                     POWER_FAIL_STATUS_REG_CLR: n.stat0 = '0;
                     WDOG_AND_POWER_STATUS_REG_CLR: begin
                        n.wdto = 1'b0;
                        n.pf1 = '0;
                     end
                     // Writes to read-only codes are dropped
                     default: n.ctrl = r.ctrl;
                  endcase
               end
            end
            SB_WDATA_ACK: begin
               // Only one data byte per transfer is taken
               n.sda_oe = 1'b0;
               n.st = SB_IGNORE;
            end
            SB_TX: begin
               if (r.cnt == 3'd7) begin
                  n.sda_oe = 1'b0;
                  n.st = SB_IGNORE;
               end else begin
                  n.cnt = r.cnt + 3'd1;
                  n.sh = {r.sh[6:0], 1'b0};
                  n.sda_oe = ~r.sh[6];
               end
            end
            default: n.sda_oe = 1'b0;
         endcase
      end

      // Sticky flags: a new event wins over a clear in the same cycle
      n.stat0 = sticky(n.stat0, pf0_evt_i & STAT0_MASK);
      n.pf1 = 5'(sticky({3'h0, n.pf1}, {3'h0, pf1_evt_i}));
      n.wdto = n.wdto | wdl.expire;

      // Handle switch, edge triggered
      n.sw_q = handle_sw_i;
      if (handle_sw_i && !r.sw_q && !r.ctrl[CTL_SW_DIS]) begin
         if (r.ctrl[CTL_SW_ACT]) begin
            rst_req = 1'b1;
         end else begin
            n.pwr_evt = 1'b1;
         end
      end

      // Full reset pulse; retriggers are ignored while it runs
      if (n.ctrl[CTL_FULL_RST] || wdl.expire) begin
         rst_req = 1'b1;
      end
      if (r.rst_cnt != 8'h00) begin
         n.rst_cnt = r.rst_cnt - 8'h01;
      end else if (rst_req) begin
         n.rst_cnt = RST_PULSE_CYC;
      end
      if (sysrst_c) begin
         // Control returns to defaults; sticky status bits are kept
         n.ctrl = CTRL_RST;
      end
      n.full_rst = (n.rst_cnt != 8'h00);

      // Indicators; blink period rides on the watchdog tick
      if (wdl.tick) begin
         if (r.blink_cnt == BLINK_HALF_MS - 10'd1) begin
            n.blink_cnt = '0;
            n.blink_ph = ~r.blink_ph;
         end else begin
            n.blink_cnt = r.blink_cnt + 10'd1;
         end
      end
      n.green = n.ctrl[CTL_GREEN];
      n.red = n.ctrl[CTL_RED] & n.blink_ph;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign sda_o = r.sda_o;
   assign sda_oe = r.sda_oe;
   assign green_indicator_on = r.green;
   assign red_indicator_out = r.red;
   assign full_reset_out = r.full_rst;
   assign power_event_out = r.pwr_evt;
endmodule : bcs_regs
`default_nettype wire

// ===== bench/bcs_host.sv
// Bus host model for the register set
`timescale 1ns/1ps
`default_nettype none
module bcs_host (
   // Clock
   input wire logic mclk,
   // Bus
   input wire logic dut_oe,
   output var logic scl,
   output wire logic sda
);
   logic h_oe = 1'b0;
   initial scl = 1'b1;
   // Open drain line with pull-up
   assign sda = !(h_oe || dut_oe);
   task automatic step(input logic s, input int k);
      scl <= s;
      repeat (k) @(posedge mclk);
   endtask : step
   // Long low phase leaves slack for the slave's registered answer
   task automatic bit_io(input logic b, output logic v);
      h_oe <= !b;
      step(1'b0, 3);
      step(1'b1, 2);
      v = sda;
      step(1'b1, 1);
      step(1'b0, 1);
   endtask : bit_io
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, a);
      ack = !a;
   endtask : byte_io
   task automatic start;
      h_oe <= 1'b0;
      step(scl, 2);
      step(1'b1, 3);
      h_oe <= 1'b1;
      step(1'b1, 3);
      step(1'b0, 2);
   endtask : start
   task automatic stop;
      h_oe <= 1'b1;
      step(1'b0, 2);
      step(1'b1, 3);
      h_oe <= 1'b0;
      step(1'b1, 3);
   endtask : stop
   task automatic wr(input logic [6:0] a, input logic [7:0] c, d, output logic ack);
      logic [7:0] q;
      logic k;
      start();
      byte_io({a, 1'b0}, q, ack);
      byte_io(c, q, k);
      byte_io(d, q, k);
      stop();
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                     output logic ack);
      logic k;
      start();
      byte_io({a, 1'b0}, d, ack);
      byte_io(c, d, k);
      start();
      byte_io({a, 1'b1}, d, k);
      byte_io(8'hff, d, k);
      stop();
   endtask : rd
endmodule : bcs_host
`default_nettype wire

// ===== bench/bcs_regs_checker.sv
// Pin assertions for the register set
`timescale 1ns/1ps
`default_nettype none
module bcs_regs_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Pins
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic sys_rst_in,
   input wire logic handle_sw_i,
   input wire logic green_indicator_on,
   input wire logic red_indicator_out,
   input wire logic full_reset_out,
   input wire logic power_event_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   drive_low_a: assert property (sda_o == 1'b0)
      else $error("sda drive not low");
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("sda_oe moved with scl high");
   pulse_len_a: assert property ($rose(full_reset_out) |-> full_reset_out[*8])
      else $error("reset pulse short");
   pulse_end_a: assert property ($fell(full_reset_out) |-> $past(full_reset_out, 10))
      else $error("reset pulse length");
   evt_single_a: assert property (power_event_out |=> !power_event_out)
      else $error("power event too long");
   evt_cause_a: assert property (power_event_out |-> $past(handle_sw_i))
      else $error("power event without press");
   green_ack_a: assert property ($rose(green_indicator_on) |-> sda_oe)
      else $error("green lit outside a write");
   sys_clr_a: assert property (sys_rst_in |-> ##2 !(green_indicator_on || red_indicator_out))
      else $error("indicators kept over reset");
   cover property ($rose(full_reset_out));
   cover property (power_event_out);
   cover property ($rose(green_indicator_on));
endmodule : bcs_regs_chk
bind bcs_regs bcs_regs_chk i_chk (.mclk, .rst, .scl_i, .sda_o, .sda_oe, .sys_rst_in,
   .handle_sw_i, .green_indicator_on, .red_indicator_out, .full_reset_out, .power_event_out);
`default_nettype wire

// ===== bench/tb_bcs_regs.sv
// Self-checking bench for the register set
`timescale 1ns/1ps
`default_nettype none
module tb_bcs_regs;
   import bcs_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic sys_rst_in = 1'b0;
   logic handle_sw_i = 1'b0;
   logic [7:0] pf0 = 8'h00;
   logic [4:0] pf1 = 5'h00;
   logic scl, sda, sda_o, sda_oe, green, red, fro, pev, ack;
   logic [7:0] q;
   int bad_count = 0;
   int num_checks = 0;
   int n, run, last_len;
   time t0;
   always #50 mclk = !mclk;
   bcs_host i_host (.mclk(mclk), .dut_oe(sda_oe), .scl(scl), .sda(sda));
   bcs_regs #(.TICK_CYC(4)) i_dut (.mclk(mclk), .rst(rst), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .sys_rst_in(sys_rst_in), .handle_sw_i(handle_sw_i),
      .pf0_evt_i(pf0), .pf1_evt_i(pf1), .green_indicator_on(green), .red_indicator_out(red),
      .full_reset_out(fro), .power_event_out(pev));
   // Length of the latest full reset pulse
   always @(posedge mclk) begin
      if (fro === 1'b1)
         run <= run + 1;
      else if (run != 0) begin
         last_len <= run;
         run <= 0;
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic w(input logic [7:0] c, d);
      i_host.wr(SLV_ADDR, c, d, ack);
      chk(32'(ack), 1);
   endtask : w
   task automatic r(input logic [7:0] c, e);
      i_host.rd(SLV_ADDR, c, q, ack);
      chk(32'(q), 32'(e));
   endtask : r
   task automatic wait_hi(input logic s, input int lim);
      for (n = 0; (s ? fro : red) !== 1'b1 && n < lim; n++) @(posedge mclk);
      if (n >= lim) begin
         bad_count++;
         $display("mismatch at %0t: wait timed out", $time);
         wrap_up();
      end
   endtask : wait_hi
   task automatic press(input logic ev);
      logic seen;
      seen = 1'b0;
      handle_sw_i <= 1'b1;
      repeat (6) @(posedge mclk) seen |= pev;
      handle_sw_i <= 1'b0;
      @(posedge mclk);
      chk(32'(seen), 32'(ev));
   endtask : press
   task automatic pulse_in(input logic [7:0] a, input logic [4:0] b, input logic s);
      pf0 <= a;
      pf1 <= b;
      sys_rst_in <= s;
      @(posedge mclk);
      pf0 <= 8'h00;
      pf1 <= 5'h00;
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : pulse_in
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      r(CMD_CTRL_RD, CTRL_RST);
      r(WDOG_POWER_STATUS_READ, 8'h00);
      w(CMD_REV_RD, 8'h5a);
      r(CMD_REV_RD, LOGIC_REV_DEF);
      i_host.rd(7'h5d, CMD_REV_RD, q, ack);
      chk(32'(ack), 0);
      w(CMD_CTRL_WR, 8'h82);
      chk(32'(green), 1);
      w(CMD_CTRL_RD, 8'h00);
      r(CMD_CTRL_RD, 8'h82);
      r(CMD_CTRL_WR, RD_UNMAPPED);
      wait_hi(1'b0, 4200);
      repeat (2010) @(posedge mclk);
      chk(32'(red), 0);
      pulse_in(8'hff, 5'h1f, 1'b0);
      pulse_in(8'h00, 5'h00, 1'b1);
      r(CMD_CTRL_RD, CTRL_RST);
      r(POWER_STATUS_READ, STAT0_MASK);
      w(POWER_FAIL_STATUS_REG_CLR, 8'h00);
      r(POWER_STATUS_READ, 8'h00);
      r(WDOG_POWER_STATUS_READ, 8'h1f);
      w(WDOG_AND_POWER_STATUS_REG_CLR, 8'hff);
      r(WDOG_POWER_STATUS_READ, 8'h00);
      press(1'b1);
      w(CMD_CTRL_WR, 8'h40);
      press(1'b0);
      w(CMD_CTRL_WR, 8'h20);
      press(1'b0);
      repeat (20) @(posedge mclk);
      r(CMD_CTRL_RD, CTRL_RST);
      w(CMD_CTRL_WR, 8'h01);
      repeat (20) @(posedge mclk);
      chk(last_len, 32'(RST_PULSE_CYC));
      r(CMD_CTRL_RD, CTRL_RST);
      w(CMD_CTRL_WR, 8'h04);
      r(WDOG_POWER_STATUS_READ, 8'h80);
      repeat (4200) @(posedge mclk);
      r(WDOG_POWER_STATUS_READ, 8'ha0);
      w(CMD_CTRL_WR, 8'h00);
      t0 = $time;
      r(WDOG_POWER_STATUS_READ, 8'h80);
      wait_hi(1'b1, 9000);
      chk(32'((($time - t0) / 100) inside {[7960:8010]}), 1);
      repeat (30) @(posedge mclk);
      r(WDOG_POWER_STATUS_READ, 8'h40);
      r(CMD_CTRL_RD, CTRL_RST);
      w(WDOG_AND_POWER_STATUS_REG_CLR, 8'h00);
      r(WDOG_POWER_STATUS_READ, 8'h00);
      w(CMD_CTRL_WR, 8'h14);
      repeat (16000) @(posedge mclk);
      r(WDOG_POWER_STATUS_READ, 8'h80);
      repeat (4000) @(posedge mclk);
      r(WDOG_POWER_STATUS_READ, 8'ha0);
      pulse_in(8'h00, 5'h00, 1'b1);
      r(WDOG_POWER_STATUS_READ, 8'h00);
      wrap_up();
   end
endmodule : tb_bcs_regs
`default_nettype wire
